// *** phi_top.sv ***
// Host port of the four-port power controller: serial target, interrupt
// pin, chip reset and per-port shutdown handling, oscillator watchdog.
// Assumes EVENT_IN, PORT_ON_REQ_IN and AC_DISC_EN_IN come from logic on
// CLK_IN; serial, strap and shutdown pins are asynchronous.
// Behaviour
// - A low chip reset holds ports off and registers at reset values.
// - Chip reset lows shorter than one microsecond are ignored.
// - The interrupt pin is pulled low while an enabled event is pending.
// - Writing one to bit 6 or 7 of register 1Ah releases the interrupt.
// - Each event is masked individually by register 01h.
// - The interrupt pin only changes between bus transactions or on a chip reset.
// - A fault during a transaction shows on the pin after the stop.
// - Only address 010 followed by the four straps is acknowledged.
// - Data comes in on a sense pin and goes out on an open-drain pin.
// - A low shutdown input holds its port off whatever is requested.
// - A low shutdown input acts like that port's pushbutton reset bit.
// - Shutdown lows shorter than one microsecond are ignored.
// - AC disconnect sensing runs only with oscillator good and enabled.
`timescale 1ns/1ps
module phi_top #(
    parameter int OSC_TIMEOUT = phi_pkg::OSC_TIMEOUT_CYCLES
) (
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic OSC_CLK_IN,
    input wire logic CHIP_RESET_N_IN,
    input wire logic SCL_IN,
    input wire logic SERIAL_DATA_SENSE_PIN_IN,
    output logic SERIAL_DATA_DRIVE_PIN_OUT,
    output logic SERIAL_DATA_DRIVE_PIN_OE_OUT,
    output logic INT_OUT,
    output logic INT_OE_OUT,
    input wire logic [3:0] ADDR_STRAP_IN,
    input wire logic [3:0] PORT_OFF_N_IN,
    input wire logic [7:0] EVENT_IN,
    input wire logic [3:0] PORT_ON_REQ_IN,
    input wire logic [3:0] AC_DISC_EN_IN,
    output logic [3:0] PORT_POWER_OUT,
    output logic [3:0] PORT_RESET_OUT,
    output logic [3:0] AC_SENSE_OUT,
    output logic OSC_FAIL_FLAG_OUT
);
    localparam int OW = $clog2(OSC_TIMEOUT + 1);
    localparam logic [OW-1:0] OSC_LAST = OW'(OSC_TIMEOUT - 1);

    logic chip_rst_n_f;
    logic chip_rst;
    logic [3:0] off_n_f;
    logic scl_m_r, scl_s_r, scl_d_r;
    logic sda_m_r, sda_s_r, sda_d_r;
    logic [3:0] strap_m_r, strap_s_r;
    logic start, stop, scl_rise, scl_fall;
    logic busy_r;
    phi_pkg::phi_state_t state_r;
    logic [3:0] cnt_r;
    logic [7:0] shift_r;
    logic rw_r, first_r, nack_r, sda_oe_r;
    logic [7:0] idx_r;
    logic [7:0] rd_data;
    logic [6:0] own_addr;
    phi_pkg::phi_wr_t wr_r;
    logic [7:0] mask_r, evt_r;
    logic int_clr, int_low_r;
    logic [3:0] pb_pulse;
    logic osc_tog_r;
    logic osc_m_r, osc_s_r, osc_d_r;
    logic [OW-1:0] osc_cnt_r;
    logic osc_fail_r;
    logic [3:0] power_r, preset_r, ac_r;

    // Chip reset is a pin, filtered then used as a synchronous clear
    phi_glitch_filter #(.FILT_CYCLES(phi_pkg::FILT_CYCLES),
        .RESET_VAL(1'b1)) u_rst_filt (
        .clk_in(CLK_IN), .rst_in(RST_IN), .pin_in(CHIP_RESET_N_IN),
        .filt_out(chip_rst_n_f));
    assign chip_rst = ~chip_rst_n_f;

    for (genvar p = 0; p < phi_pkg::N_PORTS; p++) begin : g_off
        phi_glitch_filter #(.FILT_CYCLES(phi_pkg::FILT_CYCLES),
            .RESET_VAL(1'b1)) u_off_filt (
            .clk_in(CLK_IN), .rst_in(RST_IN), .pin_in(PORT_OFF_N_IN[p]),
            .filt_out(off_n_f[p]));
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            {scl_m_r, scl_s_r, scl_d_r} <= 3'h7;
            {sda_m_r, sda_s_r, sda_d_r} <= 3'h7;
            strap_m_r <= 4'h0;
            strap_s_r <= 4'h0;
        end else begin
            scl_m_r <= SCL_IN;
            scl_s_r <= scl_m_r;
            scl_d_r <= scl_s_r;
            sda_m_r <= SERIAL_DATA_SENSE_PIN_IN;
            sda_s_r <= sda_m_r;
            sda_d_r <= sda_s_r;
            strap_m_r <= ADDR_STRAP_IN;
            strap_s_r <= strap_m_r;
        end
    end

    assign start = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
    assign stop = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
    assign scl_rise = scl_s_r & ~scl_d_r;
    assign scl_fall = ~scl_s_r & scl_d_r;
    assign own_addr = {phi_pkg::ADDR_HI, strap_s_r};

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            busy_r <= 1'b0;
        end else if (chip_rst || stop) begin
            busy_r <= 1'b0;
        end else if (start) begin
            busy_r <= 1'b1;
        end
    end

    always_comb begin
        if (idx_r == phi_pkg::REG_INT_STATUS) begin
            rd_data = evt_r;
        end else if (idx_r == phi_pkg::REG_INT_MASK) begin
            rd_data = mask_r;
        end else begin
            rd_data = 8'h00;
        end
    end

    // Serial target; the index survives a repeated start for reads
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state_r <= phi_pkg::ST_IDLE;
            cnt_r <= 4'h0;
            shift_r <= 8'h00;
            rw_r <= 1'b0;
            first_r <= 1'b0;
            nack_r <= 1'b0;
            sda_oe_r <= 1'b0;
            idx_r <= 8'h00;
            wr_r <= '0;
        end else begin
            wr_r.stb <= 1'b0;
            if (chip_rst) begin
                state_r <= phi_pkg::ST_IDLE;
                sda_oe_r <= 1'b0;
                idx_r <= 8'h00;
            end else if (start) begin
                state_r <= phi_pkg::ST_ADDR;
                cnt_r <= 4'h0;
                sda_oe_r <= 1'b0;
            end else if (stop) begin
                state_r <= phi_pkg::ST_IDLE;
                sda_oe_r <= 1'b0;
            end else begin
                case (state_r)
                    phi_pkg::ST_ADDR: begin
                        if (scl_rise) begin
                            shift_r <= {shift_r[6:0], sda_s_r};
                            cnt_r <= cnt_r + 4'h1;
                        end else if (scl_fall &&
                                cnt_r == phi_pkg::BIT_CNT_BYTE) begin
                            if (shift_r[7:1] == own_addr) begin
                                state_r <= phi_pkg::ST_ACK_ADDR;
                                sda_oe_r <= 1'b1;
                                rw_r <= shift_r[0];
                            end else begin
                                state_r <= phi_pkg::ST_IDLE;
                            end
                        end
                    end
                    phi_pkg::ST_ACK_ADDR: begin
                        if (scl_fall) begin
                            cnt_r <= 4'h0;
                            if (rw_r) begin
                                shift_r <= rd_data;
                                sda_oe_r <= ~rd_data[7];
                                state_r <= phi_pkg::ST_READ;
                            end else begin
                                sda_oe_r <= 1'b0;
                                first_r <= 1'b1;
                                state_r <= phi_pkg::ST_WRITE;
                            end
                        end
                    end
                    phi_pkg::ST_WRITE: begin
                        if (scl_rise) begin
                            shift_r <= {shift_r[6:0], sda_s_r};
                            cnt_r <= cnt_r + 4'h1;
                        end else if (scl_fall &&
                                cnt_r == phi_pkg::BIT_CNT_BYTE) begin
                            sda_oe_r <= 1'b1;
                            state_r <= phi_pkg::ST_ACK_WRITE;
                            if (first_r) begin
                                idx_r <= shift_r;
                            end else begin
                                wr_r <= '{stb: 1'b1, idx: idx_r,
                                    data: shift_r};
                            end
                        end
                    end
                    phi_pkg::ST_ACK_WRITE: begin
                        if (scl_fall) begin
                            sda_oe_r <= 1'b0;
                            cnt_r <= 4'h0;
                            state_r <= phi_pkg::ST_WRITE;
                            if (!first_r) begin
                                idx_r <= idx_r + 8'h01;
                            end
                            first_r <= 1'b0;
                        end
                    end
                    phi_pkg::ST_READ: begin
                        if (scl_rise) begin
                            cnt_r <= cnt_r + 4'h1;
                        end else if (scl_fall) begin
                            if (cnt_r == phi_pkg::BIT_CNT_BYTE) begin
                                sda_oe_r <= 1'b0;
                                idx_r <= idx_r + 8'h01;
                                state_r <= phi_pkg::ST_ACK_READ;
                            end else begin
                                shift_r <= {shift_r[6:0], 1'b0};
                                sda_oe_r <= ~shift_r[6];
                            end
                        end
                    end
                    phi_pkg::ST_ACK_READ: begin
                        if (scl_rise) begin
                            nack_r <= sda_s_r;
                        end else if (scl_fall) begin
                            cnt_r <= 4'h0;
                            if (nack_r) begin
                                state_r <= phi_pkg::ST_IDLE;
                            end else begin
                                shift_r <= rd_data;
                                sda_oe_r <= ~rd_data[7];
                                state_r <= phi_pkg::ST_READ;
                            end
                        end
                    end
                    default: begin
                        state_r <= phi_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    assign int_clr = wr_r.stb && wr_r.idx == phi_pkg::REG_PB_RESET &&
        (wr_r.data[phi_pkg::PB_INT_CLR_A] ||
        wr_r.data[phi_pkg::PB_INT_CLR_B]);
    assign pb_pulse = (wr_r.stb && wr_r.idx == phi_pkg::REG_PB_RESET) ?
        wr_r.data[3:0] : 4'h0;

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            mask_r <= phi_pkg::INT_MASK_RST;
        end else if (chip_rst) begin
            mask_r <= phi_pkg::INT_MASK_RST;
        end else if (wr_r.stb && wr_r.idx == phi_pkg::REG_INT_MASK) begin
            mask_r <= wr_r.data;
        end
    end

    // A new event in the clearing cycle stays pending
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            evt_r <= phi_pkg::INT_STATUS_RST;
        end else if (chip_rst) begin
            evt_r <= phi_pkg::INT_STATUS_RST;
        end else begin
            evt_r <= (int_clr ? 8'h00 : evt_r) | (EVENT_IN & mask_r);
        end
    end

    // Pin follows the pending state only while the bus is idle, so a
    // fault mid-transaction shows up right after the stop
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            int_low_r <= 1'b0;
        end else if (chip_rst) begin
            int_low_r <= 1'b0;
        end else if (!busy_r) begin
            int_low_r <= |evt_r;
        end
    end

    assign INT_OUT = 1'b0;
    assign INT_OE_OUT = int_low_r;
    assign SERIAL_DATA_DRIVE_PIN_OUT = 1'b0;
    assign SERIAL_DATA_DRIVE_PIN_OE_OUT = sda_oe_r;

    // Oscillator domain only toggles; the watchdog lives on CLK_IN
    always_ff @(posedge OSC_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            osc_tog_r <= 1'b0;
        end else begin
            osc_tog_r <= ~osc_tog_r;
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            {osc_m_r, osc_s_r, osc_d_r} <= 3'h0;
            osc_cnt_r <= '0;
            osc_fail_r <= 1'b0;
        end else begin
            osc_m_r <= osc_tog_r;
            osc_s_r <= osc_m_r;
            osc_d_r <= osc_s_r;
            if (osc_s_r != osc_d_r) begin
                osc_cnt_r <= '0;
                osc_fail_r <= 1'b0;
            end else if (osc_cnt_r == OSC_LAST) begin
                osc_fail_r <= 1'b1;
            end else begin
                osc_cnt_r <= osc_cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            power_r <= 4'h0;
            preset_r <= 4'h0;
            ac_r <= 4'h0;
        end else if (chip_rst) begin
            power_r <= 4'h0;
            preset_r <= 4'h0;
            ac_r <= 4'h0;
        end else begin
            power_r <= PORT_ON_REQ_IN & off_n_f & ~pb_pulse;
            preset_r <= pb_pulse | ~off_n_f;
            ac_r <= power_r & AC_DISC_EN_IN & {4{~osc_fail_r}};
        end
    end

    assign PORT_POWER_OUT = power_r;
    assign PORT_RESET_OUT = preset_r;
    assign AC_SENSE_OUT = ac_r;
    assign OSC_FAIL_FLAG_OUT = osc_fail_r;

    chip_reset_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        chip_rst |=> power_r == 4'h0 &&
        mask_r == phi_pkg::INT_MASK_RST)
        else $error("chip reset did not clear ports and mask");
    int_assert_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        !chip_rst && !busy_r && (|evt_r) |=> INT_OE_OUT)
        else $error("pending event did not pull the interrupt low");
    int_release_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        int_clr && (EVENT_IN & mask_r) == 8'h00 |=> evt_r == 8'h00)
        else $error("interrupt release write left events pending");
    mask_block_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        evt_r == 8'h00 && (EVENT_IN & mask_r) == 8'h00 |=>
        !(|evt_r))
        else $error("masked event became pending");
    int_hold_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        busy_r && !chip_rst |=> $stable(INT_OE_OUT))
        else $error("interrupt pin moved during a transaction");
    int_stop_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        stop && !chip_rst && (|evt_r) && (EVENT_IN & mask_r) == 8'h00 &&
        !int_clr |=> ##1 INT_OE_OUT)
        else $error("pending fault not shown after the stop");
    addr_ack_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        $rose(state_r == phi_pkg::ST_ACK_ADDR) |->
        $past(shift_r[7:1]) == own_addr && sda_oe_r)
        else $error("acknowledged a foreign address");
    sda_drive_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        SERIAL_DATA_DRIVE_PIN_OUT == 1'b0)
        else $error("data pin driven high");
    sda_oe_state_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        sda_oe_r |-> state_r inside {phi_pkg::ST_ACK_ADDR,
        phi_pkg::ST_ACK_WRITE, phi_pkg::ST_READ})
        else $error("data pin pulled outside ack or read bits");
    port_off_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        off_n_f != 4'hF |=> (power_r & ~$past(off_n_f)) == 4'h0 &&
        (preset_r & ~$past(off_n_f)) == ~$past(off_n_f))
        else $error("shutdown port still powered or not reset");
    ac_gate_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        osc_fail_r |=> ac_r == 4'h0)
        else $error("ac sensing with oscillator failed");

endmodule : phi_top

// *** phi_pkg.sv ***
// Shared constants and types for the port host interface block.
// Assumes CLK_IN at 50 MHz; the filter and watchdog counts derive from that rate.
package phi_pkg;

    localparam int N_PORTS = 4;

    // Fixed upper bits of the 7-bit target address
    localparam logic [2:0] ADDR_HI = 3'h2;

    // Register indices
    localparam logic [7:0] REG_INT_STATUS = 8'h00;
    localparam logic [7:0] REG_INT_MASK = 8'h01;
    localparam logic [7:0] REG_PB_RESET = 8'h1A;

    // Field positions, values after reset and the bit count of a byte
    localparam logic [7:0] INT_MASK_RST = 8'h80;
    localparam logic [7:0] INT_STATUS_RST = 8'h00;
    localparam int PB_INT_CLR_A = 6;
    localparam int PB_INT_CLR_B = 7;
    localparam logic [3:0] BIT_CNT_BYTE = 4'h8;

    // Timing
    localparam int CLK_MHZ = 50;
    localparam int FILT_NS = 1000;
    localparam int FILT_CYCLES = (FILT_NS * CLK_MHZ + 999) / 1000;
    localparam int OSC_TIMEOUT_MS = 20;
    localparam int OSC_TIMEOUT_CYCLES = OSC_TIMEOUT_MS * CLK_MHZ * 1000;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACK_ADDR = 3'b010,
        ST_WRITE = 3'b011,
        ST_ACK_WRITE = 3'b100,
        ST_READ = 3'b101,
        ST_ACK_READ = 3'b110
    } phi_state_t;

    // One register write from the serial target
    typedef struct packed {
        logic stb;
        logic [7:0] idx;
        logic [7:0] data;
    } phi_wr_t;

endpackage : phi_pkg

// *** phi_glitch_filter.sv ***
// Pin synchroniser plus glitch filter for a slow control input.
// Assumes the input is asynchronous to clk_in; output follows only a
// level that has stood for FILT_CYCLES cycles.
`timescale 1ns/1ps
module phi_glitch_filter #(
    parameter int FILT_CYCLES = phi_pkg::FILT_CYCLES,
    parameter bit RESET_VAL = 1'b1
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic pin_in,
    output logic filt_out
);
    localparam int CW = $clog2(FILT_CYCLES + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(FILT_CYCLES - 1);

    logic sync1_r;
    logic sync2_r;
    logic [CW-1:0] cnt_r;
    logic filt_r;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sync1_r <= RESET_VAL;
            sync2_r <= RESET_VAL;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
        end
    end

    // Any return to the held level restarts the count
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_r <= '0;
            filt_r <= RESET_VAL;
        end else if (sync2_r == filt_r) begin
            cnt_r <= '0;
        end else if (cnt_r == CNT_LAST) begin
            cnt_r <= '0;
            filt_r <= sync2_r;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    assign filt_out = filt_r;

    filt_stable_a: assert property (@(posedge clk_in) disable iff (rst_in)
        $changed(filt_r) |-> $past(cnt_r) == CNT_LAST)
        else $error("filter output moved before the level settled");

endmodule : phi_glitch_filter

// *** phi_host_model.sv ***
// Serial bus host model: start, stop and byte transfer tasks.
// Assumes a pull-up on the data line and the device pulling it via pull_in.
`timescale 1ns/1ps
module phi_host_model (
    input wire logic clk_in,
    input wire logic pull_in,
    output logic scl_out,
    output logic sda_out
);
    logic sda_drv = 1'b1;
    initial scl_out = 1'b1;
    // Released line floats to the pull-up level, never the last value
    assign sda_out = sda_drv & ~pull_in;
    // Eight cycles a phase stays well above the six-cycle minimum
    task automatic half();
        repeat (8) @(negedge clk_in);
    endtask : half
    task automatic start();
        sda_drv = 1'b1;
        half();
        scl_out = 1'b1;
        half();
        sda_drv = 1'b0;
        half();
        scl_out = 1'b0;
    endtask : start
    task automatic stop();
        repeat (2) @(negedge clk_in);
        sda_drv = 1'b0;
        half();
        scl_out = 1'b1;
        half();
        sda_drv = 1'b1;
        half();
    endtask : stop
    // Data moves two cycles after the clock falls, so it is never
    // mistaken for a start or stop by the synchronisers
    task automatic bit_io(input logic b, output logic r);
        repeat (2) @(negedge clk_in);
        sda_drv = b;
        half();
        scl_out = 1'b1;
        half();
        r = sda_out;
        scl_out = 1'b0;
    endtask : bit_io
    task automatic xfer(input logic [7:0] tx, input logic ack_in,
                        output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(ack_in, ack);
    endtask : xfer
endmodule : phi_host_model

// *** phi_top_bench.sv ***
// Self-checking bench for phi_top: registers over the serial bus,
// interrupt pin, chip reset and shutdown filters, oscillator watchdog.
// Assumes phi_pkg and phi_host_model are compiled first.
`timescale 1ns/1ps
module phi_top_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic osc = 1'b0;
    logic osc_run = 1'b1;
    logic chip_n = 1'b1;
    logic [3:0] straps = 4'h0;
    logic [3:0] off_n = 4'hF;
    logic [7:0] ev = 8'h00;
    logic [3:0] req = 4'hF;
    logic [3:0] ac_en = 4'h0;
    logic scl, sda, sda_oe, sda_q, int_oe, int_q, osc_fail, ack;
    logic [3:0] pwr, prst, ac, pm;
    logic [7:0] mask_m, st_m, rx;
    int err_count = 0;
    int check_count = 0;
    int cyc = 0;
    int p;
    always #10 clk = ~clk;
    always #6 if (osc_run) osc = ~osc;
    phi_top #(.OSC_TIMEOUT(64)) phi_top_i (
        .CLK_IN(clk), .RST_IN(rst), .OSC_CLK_IN(osc),
        .CHIP_RESET_N_IN(chip_n), .SCL_IN(scl),
        .SERIAL_DATA_SENSE_PIN_IN(sda), .SERIAL_DATA_DRIVE_PIN_OUT(sda_q),
        .SERIAL_DATA_DRIVE_PIN_OE_OUT(sda_oe), .INT_OUT(int_q),
        .INT_OE_OUT(int_oe), .ADDR_STRAP_IN(straps), .PORT_OFF_N_IN(off_n),
        .EVENT_IN(ev), .PORT_ON_REQ_IN(req), .AC_DISC_EN_IN(ac_en),
        .PORT_POWER_OUT(pwr), .PORT_RESET_OUT(prst), .AC_SENSE_OUT(ac),
        .OSC_FAIL_FLAG_OUT(osc_fail)
    );
    phi_host_model phi_host_model_i (
        .clk_in(clk), .pull_in(sda_oe), .scl_out(scl), .sda_out(sda)
    );
    task automatic end_of_test();
        if (err_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    function automatic logic [7:0] dev(input logic rd);
        return {phi_pkg::ADDR_HI, straps, rd};
    endfunction : dev
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        phi_host_model_i.start();
        phi_host_model_i.xfer(dev(1'b0), 1'b1, rx, ack);
        chk({7'h0, ack}, 8'h00);
        phi_host_model_i.xfer(idx, 1'b1, rx, ack);
        phi_host_model_i.xfer(d, 1'b1, rx, ack);
        phi_host_model_i.stop();
        tick(8);
    endtask : wr
    task automatic rd(input logic [7:0] idx, output logic [7:0] d);
        phi_host_model_i.start();
        phi_host_model_i.xfer(dev(1'b0), 1'b1, rx, ack);
        phi_host_model_i.xfer(idx, 1'b1, rx, ack);
        phi_host_model_i.start();
        phi_host_model_i.xfer(dev(1'b1), 1'b1, rx, ack);
        chk({7'h0, ack}, 8'h00);
        phi_host_model_i.xfer(8'hFF, 1'b1, d, ack);
        phi_host_model_i.stop();
        tick(8);
    endtask : rd
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            end_of_test();
        end
    end
    initial begin
        void'($urandom(32'hE560));
        tick(4);
        rst = 1'b0;
        straps = 4'($urandom);
        mask_m = 8'h80;
        st_m = 8'h00;
        tick(4);
        chk({7'h0, int_oe}, 8'h00);
        rd(phi_pkg::REG_INT_MASK, rx);
        chk(rx, mask_m);
        chk({7'h0, sda_q}, 8'h00);
        // Another address on the bus must not be acknowledged
        phi_host_model_i.start();
        phi_host_model_i.xfer(dev(1'b0) ^ 8'h10, 1'b1, rx, ack);
        phi_host_model_i.stop();
        chk({7'h0, ack}, 8'h01);
        mask_m = 8'($urandom) | 8'h01;
        wr(phi_pkg::REG_INT_MASK, mask_m);
        rd(phi_pkg::REG_INT_MASK, rx);
        chk(rx, mask_m);
        for (int i = 0; i < 4; i++) begin
            ev = 8'($urandom);
            st_m |= ev & mask_m;
            tick(1);
            ev = 8'h00;
            tick(4);
            chk({7'h0, int_oe}, {7'h0, st_m != 8'h00});
            chk({7'h0, int_q}, 8'h00);
            rd(phi_pkg::REG_INT_STATUS, rx);
            chk(rx, st_m);
            if (i[0]) begin
                wr(phi_pkg::REG_PB_RESET, 8'h40 << i[1]);
                st_m = 8'h00;
                chk({7'h0, int_oe}, 8'h00);
            end
        end
        // An event inside a transaction waits for the stop
        phi_host_model_i.start();
        phi_host_model_i.xfer(dev(1'b0), 1'b1, rx, ack);
        ev = 8'h01;
        tick(1);
        ev = 8'h00;
        tick(6);
        chk({7'h0, int_oe}, 8'h00);
        phi_host_model_i.xfer(8'h00, 1'b1, rx, ack);
        phi_host_model_i.stop();
        tick(8);
        chk({7'h0, int_oe}, 8'h01);
        ac_en = 4'($urandom);
        tick(4);
        chk({4'h0, ac}, {4'h0, ac_en});
        p = $urandom % 4;
        pm = 4'h1 << p;
        off_n[p] = 1'b0;
        tick(20);
        off_n[p] = 1'b1;
        tick(60);
        chk({4'h0, pwr}, 8'h0F);
        off_n[p] = 1'b0;
        tick(60);
        chk({4'h0, pwr}, {4'h0, ~pm});
        chk({4'h0, prst}, {4'h0, pm});
        off_n[p] = 1'b1;
        tick(60);
        osc_run = 1'b0;
        tick(100);
        chk({7'h0, osc_fail}, 8'h01);
        chk({4'h0, ac}, 8'h00);
        osc_run = 1'b1;
        tick(10);
        chip_n = 1'b0;
        tick(20);
        chip_n = 1'b1;
        tick(60);
        rd(phi_pkg::REG_INT_MASK, rx);
        chk(rx, mask_m);
        chip_n = 1'b0;
        tick(60);
        chk({4'h0, pwr}, 8'h00);
        chip_n = 1'b1;
        tick(60);
        rd(phi_pkg::REG_INT_MASK, rx);
        chk(rx, phi_pkg::INT_MASK_RST);
        end_of_test();
    end
endmodule : phi_top_bench
